// [pkg/nsa_pkg.sv]
package nsa_pkg;

  localparam int unsigned NUM_ENTRIES = 2;
  localparam int unsigned MAC_W       = 48;
  localparam int unsigned IP6_W       = 128;
  localparam int unsigned IP4_W       = 32;

  // ethertypes and protocol values
  localparam logic [15:0] ETYPE_IPV6  = 16'h86DD;
  localparam logic [15:0] ETYPE_ARP   = 16'h0806;
  localparam logic [7:0]  PROTO_ICMP6 = 8'h3A;
  localparam logic [7:0]  ICMP_SOLICIT = 8'h87;
  localparam logic [7:0]  ICMP_ADVERT  = 8'h88;
  localparam logic [7:0]  ICMP_CODE0   = 8'h00;
  localparam logic [7:0]  HOP_LIMIT    = 8'hFF;
  localparam logic [15:0] ICMP_LEN     = 16'h0020;
  localparam logic [7:0]  OPT_TARGET_LL = 8'h02;
  localparam logic [7:0]  OPT_LEN_ONE   = 8'h01;

  localparam logic [15:0] ARP_HTYPE_ETH = 16'h0001;
  localparam logic [15:0] ARP_PTYPE_IP4 = 16'h0800;
  localparam logic [7:0]  ARP_HLEN      = 8'h06;
  localparam logic [7:0]  ARP_PLEN      = 8'h04;
  localparam logic [15:0] ARP_OP_REQ    = 16'h0001;
  localparam logic [15:0] ARP_OP_REPLY  = 16'h0002;

  localparam logic [127:0] ALL_NODES = 128'hFF02_0000_0000_0000_0000_0000_0000_0001;
  localparam logic [103:0] SOLNODE_PREFIX = 104'hFF02_0000_0000_0000_0000_0001_FF;
  localparam int unsigned  SOLNODE_LOW = 24;

  // reply frame layout, byte 0 in the top bits
  localparam int unsigned FRAME_BYTES  = 86;
  localparam int unsigned FRAME_BITS   = FRAME_BYTES * 8;
  localparam int unsigned ARP_BYTES    = 42;
  localparam int unsigned ARP_BITS     = ARP_BYTES * 8;
  localparam int unsigned CSUM_WORDS   = 32;
  localparam int unsigned CSUM_BITS    = CSUM_WORDS * 16;
  localparam int unsigned CSUM_FIELD_LO = 224;
  // pseudo-header length plus next header
  localparam logic [15:0] CSUM_EXTRA   = 16'h005A;
  localparam logic [6:0]  LEN_NA       = 7'h56;
  localparam logic [6:0]  LEN_ARP      = 7'h2A;

  typedef enum logic [1:0] {
    NSA_IDLE,
    NSA_CSUM,
    NSA_REQ,
    NSA_SEND
  } nsa_state_t;

endpackage

// [logic/nsa_csum.sv]
module nsa_csum #(
  parameter int unsigned WORDS = 32
) (
  // message words
  input  wire logic [WORDS*16-1:0] words_in,
  input  wire logic [15:0]         extra_in,
  // ones-complement checksum
  output logic      [15:0]         csum_out
);

  logic [31:0] acc;
  logic [31:0] fold;

  always_comb begin
    acc = {16'h0000, extra_in};
    for (int i = 0; i < WORDS; i++) begin
      acc = acc + {16'h0000, words_in[i*16 +: 16]};
    end
    // two folds absorb every carry
    fold = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
    fold = {16'h0000, fold[15:0]} + {16'h0000, fold[31:16]};
    csum_out = ~fold[15:0];
  end

endmodule

// [logic/nsa_responder.sv]
// How it works
// (RULE1) inspect IPv6 frames to own, multicast, broadcast
// (RULE2) destination matches dest or target registers; source compared
// (RULE3) zero source register always matches
// (RULE4) solicited-node: compare dest bits 127:104 only
// (RULE5) require next header 58, type 135 code 0
// (RULE6) reply when target matches, checksum good, no error
// (RULE7) drop frames failing discovery receive checks
// (RULE8) reply Ethernet: requester, own station, 86DD
// (RULE9) reply source: target or entry destination register
// (RULE10) reply destination: requester or all-nodes; hop 255
// (RULE11) type 136 code 0, pseudo-header checksum
// (RULE12) flags R0 O1 S conditional, target, station option
// (RULE13) solicit flag set on arrival, resume clears
// (RULE14) host clears wake flags before suspend
// (RULE15) resolution: 0806 to own or broadcast only
// (RULE16) check hardware, protocol, lengths, request opcode
// (RULE17) reply when sender and target addresses match
// (RULE18) reply Ethernet: requester, own station, 0806
// (RULE19) reply body fields swapped from request
// (RULE20) resolve flag set on request, resume clears
// (RULE21) host must clear resolve enable when normal
// (RULE22) two independent solicitation entries
// (RULE23) answering never raises a wake event
// (RULE24) hold reply until granted, never cut frame
module nsa_responder #(
  parameter int unsigned ENTRIES = nsa_pkg::NUM_ENTRIES
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // control
  input  wire logic [47:0]            station_addr_in,
  input  wire logic                   solicit_offload_enable_in,
  input  wire logic                   resolve_offload_enable_in,
  input  wire logic                   advert_source_select_in,
  input  wire logic                   resume_clears_wake_flags_in,
  input  wire logic                   suspend_exit_in,
  input  wire logic                   solicit_flag_clear_in,
  input  wire logic                   resolve_flag_clear_in,
  // solicitation entries, entry 0 low
  input  wire logic [ENTRIES*128-1:0] solicit_entry_dest_addr_in,
  input  wire logic [ENTRIES*128-1:0] solicit_entry_src_addr_in,
  input  wire logic [ENTRIES*128-1:0] solicit_entry_target_a_in,
  input  wire logic [ENTRIES*128-1:0] solicit_entry_target_b_in,
  input  wire logic [31:0]            resolve_sender_proto_match_in,
  input  wire logic [31:0]            resolve_target_proto_match_in,
  // parsed receive frame, one-cycle valid
  input  wire logic                   rx_frame_valid_in,
  input  wire logic                   rx_frame_error_in,
  input  wire logic [47:0]            rx_eth_dest_in,
  input  wire logic [47:0]            rx_eth_src_in,
  input  wire logic [15:0]            rx_ethertype_in,
  input  wire logic [127:0]           rx_ip6_src_in,
  input  wire logic [127:0]           rx_ip6_dst_in,
  input  wire logic [7:0]             rx_upper_proto_in,
  input  wire logic [7:0]             rx_icmp_type_in,
  input  wire logic [7:0]             rx_icmp_code_in,
  input  wire logic                   rx_icmp_csum_ok_in,
  input  wire logic                   rx_nd_checks_ok_in,
  input  wire logic [127:0]           rx_ns_target_in,
  input  wire logic [15:0]            rx_arp_htype_in,
  input  wire logic [15:0]            rx_arp_ptype_in,
  input  wire logic [7:0]             rx_arp_hlen_in,
  input  wire logic [7:0]             rx_arp_plen_in,
  input  wire logic [15:0]            rx_arp_oper_in,
  input  wire logic [47:0]            rx_arp_sha_in,
  input  wire logic [31:0]            rx_resolve_sender_proto_match_in,
  input  wire logic [31:0]            rx_resolve_target_proto_match_in,
  // transmit client
  input  wire logic                   tx_grant_in,
  input  wire logic                   tx_ready_in,
  output logic                        tx_req_out,
  output logic                        tx_valid_out,
  output logic [7:0]                  tx_data_out,
  output logic                        tx_last_out,
  // status
  output logic                        solicit_received_flag_out,
  output logic                        resolve_received_flag_out,
  output logic                        busy_out
);

  localparam int unsigned FB = nsa_pkg::FRAME_BITS;

  function automatic logic [7:0] byte_at(input logic [FB-1:0] buf_v, input logic [6:0] idx);
    byte_at = buf_v[(FB - 8 - 8 * int'(idx)) +: 8];
  endfunction

  // receive classification
  logic eth_multi;
  logic eth_bcast;
  logic eth_own;
  logic solnode;
  logic [ENTRIES-1:0] ent_addr_ok;
  logic [ENTRIES-1:0] ent_tgt_ok;

  assign eth_bcast = (rx_eth_dest_in == 48'hFFFF_FFFF_FFFF);
  assign eth_multi = rx_eth_dest_in[40];
  assign eth_own   = (rx_eth_dest_in == station_addr_in);
  assign solnode   = (rx_ip6_dst_in[127:24] == nsa_pkg::SOLNODE_PREFIX); // RULE4

  for (genvar e = 0; e < ENTRIES; e++) begin : g_ent // RULE22
    logic [127:0] d;
    logic [127:0] s;
    logic [127:0] ta;
    logic [127:0] tb;
    logic         dst_ok;
    logic         src_ok;
    assign d  = solicit_entry_dest_addr_in[e*128 +: 128];
    assign s  = solicit_entry_src_addr_in[e*128 +: 128];
    assign ta = solicit_entry_target_a_in[e*128 +: 128];
    assign tb = solicit_entry_target_b_in[e*128 +: 128];
    assign dst_ok = (solnode ? (d[127:104] == rx_ip6_dst_in[23:0]) // RULE4
                             : (rx_ip6_dst_in == d))
                    || rx_ip6_dst_in == ta || rx_ip6_dst_in == tb; // RULE2
    assign src_ok = (s == 128'h0) || (s == rx_ip6_src_in); // RULE2 RULE3
    assign ent_addr_ok[e] = dst_ok && src_ok;
    assign ent_tgt_ok[e]  = ent_addr_ok[e]
                            && (rx_ns_target_in == ta || rx_ns_target_in == tb); // RULE6
  end

  logic ns_seen;
  logic ns_reply;
  logic arp_seen;
  logic arp_reply;
  logic [127:0] sel_dest;

  always_comb begin
    sel_dest = solicit_entry_dest_addr_in[127:0];
    for (int e = ENTRIES - 1; e >= 0; e--) begin
      if (ent_tgt_ok[e]) begin
        sel_dest = solicit_entry_dest_addr_in[e*128 +: 128];
      end
    end
  end

  assign ns_seen = rx_frame_valid_in && solicit_offload_enable_in
                   && (eth_own || eth_multi || eth_bcast) // RULE1
                   && rx_ethertype_in == nsa_pkg::ETYPE_IPV6
                   && (|ent_addr_ok)
                   && rx_upper_proto_in == nsa_pkg::PROTO_ICMP6 // RULE5
                   && rx_icmp_type_in == nsa_pkg::ICMP_SOLICIT
                   && rx_icmp_code_in == nsa_pkg::ICMP_CODE0;
  assign ns_reply = ns_seen && (|ent_tgt_ok) && rx_icmp_csum_ok_in // RULE6
                    && !rx_frame_error_in && rx_nd_checks_ok_in; // RULE7

  assign arp_seen = rx_frame_valid_in && resolve_offload_enable_in
                    && rx_ethertype_in == nsa_pkg::ETYPE_ARP
                    && (eth_own || eth_bcast) // RULE15
                    && rx_arp_htype_in == nsa_pkg::ARP_HTYPE_ETH // RULE16
                    && rx_arp_ptype_in == nsa_pkg::ARP_PTYPE_IP4
                    && rx_arp_hlen_in == nsa_pkg::ARP_HLEN
                    && rx_arp_plen_in == nsa_pkg::ARP_PLEN
                    && rx_arp_oper_in == nsa_pkg::ARP_OP_REQ;
  assign arp_reply = arp_seen && !rx_frame_error_in
                     && rx_resolve_sender_proto_match_in == resolve_sender_proto_match_in // RULE17
                     && rx_resolve_target_proto_match_in == resolve_target_proto_match_in;

  // reply frame images
  logic [127:0] na_src;
  logic [127:0] na_dst;
  logic         solicited;
  logic [FB-1:0] na_img;
  logic [FB-1:0] arp_img;

  assign na_src    = advert_source_select_in ? sel_dest : rx_ns_target_in; // RULE9
  assign na_dst    = (rx_ip6_src_in == 128'h0) ? nsa_pkg::ALL_NODES : rx_ip6_src_in; // RULE10
  assign solicited = (na_dst != nsa_pkg::ALL_NODES); // RULE12

  assign na_img = {rx_eth_src_in, station_addr_in, nsa_pkg::ETYPE_IPV6, // RULE8
                   4'h6, 8'h00, 20'h00000, nsa_pkg::ICMP_LEN,
                   nsa_pkg::PROTO_ICMP6, nsa_pkg::HOP_LIMIT, na_src, na_dst, // RULE10
                   nsa_pkg::ICMP_ADVERT, nsa_pkg::ICMP_CODE0, 16'h0000, // RULE11
                   1'b0, solicited, 1'b1, 29'h00000000, rx_ns_target_in, // RULE12
                   nsa_pkg::OPT_TARGET_LL, nsa_pkg::OPT_LEN_ONE, station_addr_in};

  // shorter reply sits left-aligned, tail never sent
  assign arp_img = {rx_eth_src_in, station_addr_in, nsa_pkg::ETYPE_ARP, // RULE18
                    nsa_pkg::ARP_HTYPE_ETH, nsa_pkg::ARP_PTYPE_IP4, // RULE19
                    nsa_pkg::ARP_HLEN, nsa_pkg::ARP_PLEN, nsa_pkg::ARP_OP_REPLY,
                    station_addr_in, rx_resolve_target_proto_match_in, rx_arp_sha_in, rx_resolve_sender_proto_match_in,
                    {(FB - nsa_pkg::ARP_BITS){1'b0}}};

  logic [FB-1:0] frame_buf;
  logic [15:0] csum;

  nsa_csum #(
    .WORDS (nsa_pkg::CSUM_WORDS)
  ) u_csum (
    .words_in (frame_buf[nsa_pkg::CSUM_BITS-1:0]),
    .extra_in (nsa_pkg::CSUM_EXTRA),
    .csum_out (csum)
  );

  // reply sequencer
  nsa_pkg::nsa_state_t state;
  nsa_pkg::nsa_state_t next_state;
  logic [FB-1:0] next_frame_buf;
  logic [6:0]    frame_len;
  logic [6:0]    next_frame_len;
  logic [6:0]    idx;
  logic [6:0]    next_idx;
  logic          next_tx_req;
  logic          next_tx_valid;
  logic [7:0]    next_tx_data;
  logic          next_tx_last;

  // replies arriving while one is pending are dropped, no queue
  always_comb begin
    next_state     = state;
    next_frame_buf = frame_buf;
    next_frame_len = frame_len;
    next_idx       = idx;
    next_tx_req    = tx_req_out;
    next_tx_valid  = tx_valid_out;
    next_tx_data   = tx_data_out;
    next_tx_last   = tx_last_out;
    case (state)
      nsa_pkg::NSA_IDLE: begin
        if (ns_reply) begin
          next_frame_buf = na_img;
          next_frame_len = nsa_pkg::LEN_NA;
          next_state     = nsa_pkg::NSA_CSUM;
        end else if (arp_reply) begin
          next_frame_buf = arp_img;
          next_frame_len = nsa_pkg::LEN_ARP;
          next_state     = nsa_pkg::NSA_REQ;
          next_tx_req    = 1'b1;
        end
      end
      nsa_pkg::NSA_CSUM: begin
        next_frame_buf[nsa_pkg::CSUM_FIELD_LO +: 16] = csum; // RULE11
        next_state  = nsa_pkg::NSA_REQ;
        next_tx_req = 1'b1;
      end
      nsa_pkg::NSA_REQ: begin
        if (tx_grant_in) begin // RULE24
          next_state    = nsa_pkg::NSA_SEND;
          next_tx_valid = 1'b1;
          next_tx_data  = byte_at(frame_buf, 7'h00);
          next_tx_last  = 1'b0;
          next_idx      = 7'h01;
        end
      end
      nsa_pkg::NSA_SEND: begin
        if (tx_ready_in) begin
          if (tx_last_out) begin
            next_state    = nsa_pkg::NSA_IDLE;
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            next_tx_req   = 1'b0; // RULE24
          end else begin
            next_tx_data = byte_at(frame_buf, idx);
            next_tx_last = (idx == frame_len - 7'h01);
            next_idx     = idx + 7'h01;
          end
        end
      end
      default: begin
        next_state    = nsa_pkg::NSA_IDLE;
        next_tx_req   = 1'b0;
        next_tx_valid = 1'b0;
        next_tx_last  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state        <= nsa_pkg::NSA_IDLE;
      frame_buf    <= '0;
      frame_len    <= 7'h00;
      idx          <= 7'h00;
      tx_req_out   <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
      tx_last_out  <= 1'b0;
    end else begin
      state        <= next_state;
      frame_buf    <= next_frame_buf;
      frame_len    <= next_frame_len;
      idx          <= next_idx;
      tx_req_out   <= next_tx_req;
      tx_valid_out <= next_tx_valid;
      tx_data_out  <= next_tx_data;
      tx_last_out  <= next_tx_last;
    end
  end

  // status flags
  // no wake output exists; flags only record arrivals
  logic next_sol_flag;
  logic next_res_flag;
  logic next_busy;
  logic flag_clear_resume;

  always_comb begin
    flag_clear_resume = suspend_exit_in && resume_clears_wake_flags_in;
    // a new arrival beats a same-cycle clear
    next_sol_flag = ns_seen // RULE13 RULE23
                    || (solicit_received_flag_out
                        && !solicit_flag_clear_in && !flag_clear_resume);
    next_res_flag = arp_seen // RULE20
                    || (resolve_received_flag_out
                        && !resolve_flag_clear_in && !flag_clear_resume);
    next_busy     = (next_state != nsa_pkg::NSA_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      solicit_received_flag_out <= 1'b0;
      resolve_received_flag_out <= 1'b0;
      busy_out                  <= 1'b0;
    end else begin
      solicit_received_flag_out <= next_sol_flag;
      resolve_received_flag_out <= next_res_flag;
      busy_out                  <= next_busy;
    end
  end

endmodule

// [dv/nsa_responder_assertions.sv]
module nsa_responder_assertions (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // controls and receive
  input wire logic       solicit_offload_enable_in,
  input wire logic       resolve_offload_enable_in,
  input wire logic       resume_clears_wake_flags_in,
  input wire logic       suspend_exit_in,
  input wire logic       solicit_flag_clear_in,
  input wire logic       rx_frame_valid_in,
  input wire logic [7:0] rx_icmp_type_in,
  input wire logic [15:0] rx_arp_oper_in,
  // transmit and status
  input wire logic       tx_grant_in,
  input wire logic       tx_ready_in,
  input wire logic       tx_req_out,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_last_out,
  input wire logic       solicit_received_flag_out,
  input wire logic       resolve_received_flag_out,
  input wire logic       busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_stalled;
    tx_valid_out && !tx_ready_in;
  endsequence
  sequence s_last_taken;
    tx_valid_out && tx_ready_in && tx_last_out;
  endsequence
  a_start_granted: assert property (
    $rose(tx_valid_out) |-> $past(tx_req_out && tx_grant_in)) else $error("byte before grant");
  a_byte_held: assert property (
    s_stalled |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("byte changed while stalled");
  a_frame_ends: assert property (
    s_last_taken |=> !tx_valid_out && !tx_req_out && !busy_out) else $error("frame did not end");
  a_valid_in_req: assert property (
    tx_valid_out |-> tx_req_out && busy_out) else $error("byte outside request");
  a_idle_no_reply: assert property (
    rx_frame_valid_in && !solicit_offload_enable_in && !resolve_offload_enable_in && !busy_out
    |=> !busy_out) else $error("reply while offloads off");
  a_solicit_cause: assert property (
    $rose(solicit_received_flag_out) |-> $past(rx_frame_valid_in && solicit_offload_enable_in
    && rx_icmp_type_in == 8'h87)) else $error("solicit flag without cause");
  a_resolve_cause: assert property (
    $rose(resolve_received_flag_out) |-> $past(rx_frame_valid_in && resolve_offload_enable_in
    && rx_arp_oper_in == 16'h0001)) else $error("resolve flag without cause");
  a_resume_clears: assert property (
    suspend_exit_in && resume_clears_wake_flags_in && !rx_frame_valid_in
    |=> !solicit_received_flag_out && !resolve_received_flag_out) else $error("flags kept");
  a_flag_sticks: assert property (
    solicit_received_flag_out && !solicit_flag_clear_in && !suspend_exit_in
    |=> solicit_received_flag_out) else $error("solicit flag lost");
endmodule

bind nsa_responder nsa_responder_assertions i_chk (
  .clk_in, .rst_n_in, .solicit_offload_enable_in, .resolve_offload_enable_in,
  .resume_clears_wake_flags_in, .suspend_exit_in, .solicit_flag_clear_in, .rx_frame_valid_in,
  .rx_icmp_type_in, .rx_arp_oper_in, .tx_grant_in, .tx_ready_in, .tx_req_out, .tx_valid_out,
  .tx_data_out, .tx_last_out, .solicit_received_flag_out, .resolve_received_flag_out, .busy_out
);

// [dv/nsa_mac_tx_model.sv]
module nsa_mac_tx_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // stall every other cycle when high
  input  wire logic       slow_in,
  // client side
  input  wire logic       tx_req_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_last_in,
  output logic            tx_grant_out,
  output logic            tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frame [0:127];
  int         n;
  int         len;
  int         done;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {tx_grant_out, tx_ready_out} <= 2'b00;
      n <= 0;
      done <= 0;
    end else begin
      tx_grant_out <= tx_req_in;
      tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
      if (tx_valid_in && tx_ready_out) begin
        frame[n] <= tx_data_in;
        n <= tx_last_in ? 0 : n + 1;
        if (tx_last_in) begin
          len <= n + 1;
          done <= done + 1;
        end
      end
    end
  end
endmodule

// [dv/nsa_responder_bench.sv]
module nsa_responder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0]  ST = 48'h0211_2233_4455;
  localparam logic [47:0]  RQ = 48'h0ABB_CCDD_EE01;
  localparam logic [127:0] D0 = {32'h2001_0DB8, 96'h10};
  localparam logic [127:0] S0 = {16'hFE80, 112'h99};
  localparam logic [127:0] T0 = {32'h2001_0DB8, 96'h11};
  localparam logic [127:0] D1 = {24'hABCDEF, 104'h0};
  localparam logic [127:0] SN = 128'hFF02_0000_0000_0000_0000_0001_FFAB_CDEF;
  localparam logic [127:0] T1 = {16'hFE80, 112'h77};
  localparam logic [31:0]  SP = 32'h0A00_0002;
  localparam logic [31:0]  TP = 32'h0A00_0001;
  logic         clk_in, rst_n_in, slow, tx_grant_in, tx_ready_in;
  logic         solicit_offload_enable_in, resolve_offload_enable_in, advert_source_select_in;
  logic         resume_clears_wake_flags_in, suspend_exit_in;
  logic         solicit_flag_clear_in, resolve_flag_clear_in;
  logic [255:0] solicit_entry_dest_addr_in, solicit_entry_src_addr_in;
  logic [255:0] solicit_entry_target_a_in, solicit_entry_target_b_in;
  logic [31:0]  resolve_sender_proto_match_in, resolve_target_proto_match_in;
  logic [31:0]  rx_resolve_sender_proto_match_in, rx_resolve_target_proto_match_in;
  logic         rx_frame_valid_in, rx_frame_error_in, rx_icmp_csum_ok_in, rx_nd_checks_ok_in;
  logic [47:0]  station_addr_in, rx_eth_dest_in, rx_eth_src_in, rx_arp_sha_in;
  logic [15:0]  rx_ethertype_in, rx_arp_htype_in, rx_arp_ptype_in, rx_arp_oper_in;
  logic [127:0] rx_ip6_src_in, rx_ip6_dst_in, rx_ns_target_in;
  logic [7:0]   rx_upper_proto_in, rx_icmp_type_in, rx_icmp_code_in;
  logic [7:0]   rx_arp_hlen_in, rx_arp_plen_in;
  logic         tx_req_out, tx_valid_out, tx_last_out, busy_out;
  logic [7:0]   tx_data_out;
  logic         solicit_received_flag_out, resolve_received_flag_out;
  int           err_total, num_checks;

  nsa_responder i_dut (
    .clk_in, .rst_n_in, .station_addr_in, .solicit_offload_enable_in, .resolve_offload_enable_in,
    .advert_source_select_in, .resume_clears_wake_flags_in, .suspend_exit_in,
    .solicit_flag_clear_in, .resolve_flag_clear_in, .solicit_entry_dest_addr_in,
    .solicit_entry_src_addr_in, .solicit_entry_target_a_in, .solicit_entry_target_b_in,
    .resolve_sender_proto_match_in, .resolve_target_proto_match_in, .rx_frame_valid_in,
    .rx_frame_error_in, .rx_eth_dest_in, .rx_eth_src_in, .rx_ethertype_in, .rx_ip6_src_in,
    .rx_ip6_dst_in, .rx_upper_proto_in, .rx_icmp_type_in, .rx_icmp_code_in, .rx_icmp_csum_ok_in,
    .rx_nd_checks_ok_in, .rx_ns_target_in, .rx_arp_htype_in, .rx_arp_ptype_in, .rx_arp_hlen_in,
    .rx_arp_plen_in, .rx_arp_oper_in, .rx_arp_sha_in, .rx_resolve_sender_proto_match_in, .rx_resolve_target_proto_match_in,
    .tx_grant_in, .tx_ready_in, .tx_req_out, .tx_valid_out, .tx_data_out, .tx_last_out,
    .solicit_received_flag_out, .resolve_received_flag_out, .busy_out
  );
  nsa_mac_tx_model i_mac (
    .clk_in, .rst_n_in, .slow_in(slow), .tx_req_in(tx_req_out), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_last_in(tx_last_out), .tx_grant_out(tx_grant_in),
    .tx_ready_out(tx_ready_in)
  );

  always #20 clk_in = ~clk_in;

  task automatic chk(string nm, logic [127:0] got, logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [127:0] fb(int a, int n);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < n; i++) v = {v[119:0], i_mac.frame[a+i]};
    return v;
  endfunction
  function automatic logic [15:0] sum16();
    logic [31:0] s;
    s = 32'h20 + 32'h3A;
    for (int i = 22; i < 86; i += 2) s += {i_mac.frame[i], i_mac.frame[i+1]};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return s[15:0];
  endfunction
  task automatic set_ns(logic [127:0] da, logic [127:0] sa, logic [127:0] tg);
    {rx_eth_dest_in, rx_eth_src_in, rx_ethertype_in} = {ST, RQ, 16'h86DD};
    {rx_ip6_dst_in, rx_ip6_src_in, rx_ns_target_in} = {da, sa, tg};
    {rx_upper_proto_in, rx_icmp_type_in, rx_icmp_code_in} = 24'h3A_8700;
    {rx_icmp_csum_ok_in, rx_nd_checks_ok_in, rx_frame_error_in} = 3'b110;
  endtask
  task automatic set_arp(logic [47:0] da);
    {rx_eth_dest_in, rx_eth_src_in, rx_ethertype_in, rx_frame_error_in} = {da, RQ, 16'h0806, 1'b0};
    {rx_arp_htype_in, rx_arp_ptype_in, rx_arp_hlen_in, rx_arp_plen_in} = 48'h0001_0800_0604;
    {rx_arp_oper_in, rx_arp_sha_in, rx_resolve_sender_proto_match_in, rx_resolve_target_proto_match_in} = {16'h0001, RQ, SP, TP};
  endtask
  task automatic pulse();
    rx_frame_valid_in = 1'b1;
    @(negedge clk_in);
    rx_frame_valid_in = 1'b0;
  endtask
  task automatic quiet();
    pulse();
    repeat (4) @(negedge clk_in);
    chk("no reply", {busy_out, tx_req_out}, 2'b00);
  endtask
  task automatic reply(int len);
    int c;
    c = i_mac.done;
    for (int k = 0; k < 500 && i_mac.done == c; k++) @(negedge clk_in);
    chk("frames", i_mac.done - c, 1);
    chk("length", i_mac.len, len);
  endtask
  task automatic check_na(logic [127:0] sa, logic [127:0] da, logic [127:0] tg, logic [7:0] fl);
    reply(86);
    chk("eth da", fb(0, 6), RQ);
    chk("eth sa", fb(6, 6), ST);
    chk("etype", fb(12, 2), 16'h86DD);
    chk("hop", fb(21, 1), 8'hFF);
    chk("ip sa", fb(22, 16), sa);
    chk("ip da", fb(38, 16), da);
    chk("icmp", fb(54, 2), 16'h8800);
    chk("flags", fb(58, 4), {fl, 24'h0});
    chk("target", fb(62, 16), tg);
    chk("option", fb(78, 8), {16'h0201, ST});
    chk("csum", sum16(), 16'hFFFF);
  endtask

  initial begin
    {err_total, num_checks} = '0;
    {clk_in, rst_n_in, slow, rx_frame_valid_in, advert_source_select_in} = '0;
    {resume_clears_wake_flags_in, suspend_exit_in, solicit_flag_clear_in} = '0;
    {solicit_offload_enable_in, resolve_offload_enable_in, resolve_flag_clear_in} = 3'b110;
    station_addr_in = ST;
    {solicit_entry_dest_addr_in, solicit_entry_src_addr_in} = {D1, D0, 128'h0, S0};
    {solicit_entry_target_a_in, solicit_entry_target_b_in} = {T1 + 128'h1, T0, T1, T0 + 128'h1};
    {resolve_sender_proto_match_in, resolve_target_proto_match_in} = {SP, TP};
    set_arp(ST);
    set_ns(D0, S0, T0);
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    set_ns(D0, S0, T0 + 128'h1);
    pulse();
    check_na(T0 + 128'h1, S0, T0 + 128'h1, 8'h60);
    chk("ns flag", solicit_received_flag_out, 1'b1);
    solicit_flag_clear_in = 1'b1;
    @(negedge clk_in);
    solicit_flag_clear_in = 1'b0;
    chk("ns flag clr", solicit_received_flag_out, 1'b0);
    {slow, advert_source_select_in} = 2'b11;
    set_ns(SN, 128'h0, T1);
    pulse();
    check_na(D1, nsa_pkg::ALL_NODES, T1, 8'h20);
    {slow, advert_source_select_in} = 2'b00;
    set_ns(T0, S0, T0);
    rx_eth_dest_in = 48'hFFFF_FFFF_FFFF;
    pulse();
    reply(86);
    for (int k = 0; k < 9; k++) begin
      set_ns(T0, S0, T0);
      case (k)
        0: rx_eth_dest_in = 48'h0200_0000_0009;
        1: rx_ip6_src_in = S0 ^ 128'h1;
        2: rx_upper_proto_in = 8'h06;
        3: rx_icmp_code_in = 8'h01;
        4: rx_ns_target_in = T0 ^ 128'h4;
        5: rx_icmp_csum_ok_in = 1'b0;
        6: rx_frame_error_in = 1'b1;
        7: rx_nd_checks_ok_in = 1'b0;
        default: {solicit_offload_enable_in, resolve_offload_enable_in} = 2'b00;
      endcase
      quiet();
    end
    {solicit_offload_enable_in, resolve_offload_enable_in} = 2'b11;
    set_arp(48'hFFFF_FFFF_FFFF);
    pulse();
    reply(42);
    chk("eth da", fb(0, 6), RQ);
    chk("eth sa", fb(6, 6), ST);
    chk("etype", fb(12, 2), 16'h0806);
    chk("fixed", fb(14, 8), 64'h0001_0800_0604_0002);
    chk("sender", fb(22, 10), {ST, TP});
    chk("target", fb(32, 10), {RQ, SP});
    for (int k = 0; k < 8; k++) begin
      set_arp(ST);
      case (k)
        0: rx_eth_dest_in = 48'h0100_5E00_0001;
        1: rx_arp_htype_in = 16'h0006;
        2: rx_arp_ptype_in = 16'h86DD;
        3: rx_arp_hlen_in = 8'h08;
        4: rx_arp_plen_in = 8'h10;
        5: rx_arp_oper_in = 16'h0002;
        6: rx_resolve_sender_proto_match_in = TP;
        default: rx_resolve_target_proto_match_in = SP;
      endcase
      quiet();
    end
    chk("flags", {solicit_received_flag_out, resolve_received_flag_out}, 2'b11);
    suspend_exit_in = 1'b1;
    @(negedge clk_in);
    chk("kept", {solicit_received_flag_out, resolve_received_flag_out}, 2'b11);
    resume_clears_wake_flags_in = 1'b1;
    @(negedge clk_in);
    suspend_exit_in = 1'b0;
    chk("resumed", {solicit_received_flag_out, resolve_received_flag_out}, 2'b00);
    {solicit_offload_enable_in, resolve_offload_enable_in} = 2'b00;
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    wrap_up();
  end
endmodule
